// ===== rtl/rca_pkg.sv
// rca_pkg: constants shared by the ramp-compare converter sequencer
// assumes: single 200 mhz system clock, apb register access
package rca_pkg;
  // timing
  localparam int  RCA_CLK_HZ       = 200_000_000;
  localparam int  RCA_BUS_HZ       = 8_000_000;
  localparam int  RCA_BUS_DIV      = RCA_CLK_HZ / RCA_BUS_HZ;
  localparam int  RCA_PRESCALE     = 128;
  localparam int  RCA_DISCH_LOOPS  = 'hfe;
  // lookup table geometry
  localparam int  RCA_TBL_DEPTH    = 256;
  localparam int  RCA_PAGE_BYTES   = 64;
  localparam logic [15:0] RCA_TBL_BASE = 16'h3e00;
  localparam logic [7:0]  RCA_WIN_BASE = 8'hc0;
  localparam logic [7:0]  RCA_LOW_MASK = 8'h3f;
  // apb register byte offsets
  localparam logic [7:0] RCA_REG_CTRL   = 8'h00;
  localparam logic [7:0] RCA_REG_STATUS = 8'h04;
  localparam logic [7:0] RCA_REG_COUNT  = 8'h08;
  localparam logic [7:0] RCA_REG_RESULT = 8'h0c;
  localparam logic [7:0] RCA_REG_PAGE   = 8'h10;
  // control bit positions
  localparam int RCA_CTRL_START = 0;
  localparam int RCA_CTRL_STOP  = 1;
  // status bit positions
  localparam int RCA_ST_BUSY = 0;
  localparam int RCA_ST_DONE = 1;
  localparam int RCA_ST_CMP  = 2;
  localparam int RCA_ST_OVF  = 3;
  localparam logic [7:0] RCA_PAGE_RST = 8'h00;

  typedef enum logic [2:0] {
    RCA_IDLE   = 3'b000,
    RCA_DISCH  = 3'b001,
    RCA_RAMP   = 3'b010,
    RCA_CAPT   = 3'b011,
    RCA_LOOKUP = 3'b100,
    RCA_STORE  = 3'b101
  } rca_state_type;
endpackage

// ===== rtl/rca_prescaler.sv
// rca_prescaler: one-cycle enable at the bus rate divided by the prescale
// assumes: clear held while the conversion timer is stopped
`timescale 1ns/1ps
`default_nettype none
module rca_prescaler #(
  parameter int DIV = 3200
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  // control
  input  wire logic clear_i,
  output logic      tick_o
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt_ff;
  wire          wrap = (cnt_ff == W'(DIV - 1));

  initial begin
    if (DIV < 2) $error("prescaler divide must be at least 2");
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || clear_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
      tick_o <= wrap;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/rca_table_rom.sv
// rca_table_rom: 256-byte conversion table, four 64-byte pages
// assumes: read data registered, one cycle latency
`timescale 1ns/1ps
`default_nettype none
module rca_table_rom (
  // clock
  input  wire logic       clk_sys_i,
  // read port: page and in-window byte address
  input  wire logic [7:0] page_i,
  input  wire logic [7:0] win_addr_i,
  output logic      [7:0] data_o
);
  import rca_pkg::*;
  localparam logic [7:0] PG0 = 8'(RCA_TBL_BASE >> 6);

  wire [7:0] idx = {6'(page_i - PG0), 2'b00} << 4 |
                   (win_addr_i & RCA_LOW_MASK);

  // fixed monotonic ramp response, computed from the index on each read
  function automatic logic [7:0] tbl(input logic [7:0] i);
    int v;
    v = 255 - ((255 - i) * (255 - i)) / 255;
    return 8'(v);
  endfunction

  always_ff @(posedge clk_sys_i) begin
    data_o <= tbl(idx);
  end
endmodule
`default_nettype wire

// ===== rtl/rca_sequencer.sv
// rca_sequencer: single-slope 8-bit conversion sequencer with apb registers
// assumes: external rc node on ramp_node_pin, comparator level input
`timescale 1ns/1ps
`default_nettype none
module rca_sequencer
  import rca_pkg::*;
#(
  parameter int BUS_DIV  = rca_pkg::RCA_BUS_DIV,
  parameter int PRESCALE = rca_pkg::RCA_PRESCALE
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // ramp node pin
  input  wire logic        ramp_node_pin_i,
  output logic             ramp_node_pin_o,
  output logic             ramp_node_pin_oe_o,
  // comparator
  input  wire logic        ramp_comparator_i,
  output logic             ramp_comparator_en_o,
  output logic             ramp_comparator_edge_o
);
  import rca_pkg::*;

  initial begin
    // the bus-rate divider counter is eight bits wide
    if (BUS_DIV < 1 || BUS_DIV > 256 || PRESCALE < 2) begin
      $error("bad divider parameters");
    end
  end

  // ------------------------------------------------------------------
  // bus-rate enable
  // ------------------------------------------------------------------
  logic [7:0] bdiv_ff;
  logic       bus_en_ff;
  wire        bdiv_wrap = (bdiv_ff == 8'(BUS_DIV - 1));
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bdiv_ff   <= 8'h00;
      bus_en_ff <= 1'b0;
    end else begin
      bdiv_ff   <= bdiv_wrap ? 8'h00 : bdiv_ff + 8'h01;
      bus_en_ff <= bdiv_wrap;
    end
  end

  // ------------------------------------------------------------------
  // comparator synchroniser and edge detect
  // ------------------------------------------------------------------
  logic cmp_s1_ff;
  logic cmp_s2_ff;
  logic cmp_s3_ff;
  logic pin_s1_ff;
  logic pin_s2_ff;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
      cmp_s3_ff <= 1'b0;
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
    end else begin
      cmp_s1_ff <= ramp_comparator_i;
      cmp_s2_ff <= cmp_s1_ff;
      cmp_s3_ff <= cmp_s2_ff;
      pin_s1_ff <= ramp_node_pin_i;
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire cmp_rise = cmp_s2_ff & ~cmp_s3_ff;

  // ------------------------------------------------------------------
  // state and datapath registers
  // ------------------------------------------------------------------
  rca_state_type state_ff;
  rca_state_type nxt_state;
  logic [7:0]    disch_ff;
  logic          tmr_run_ff;
  logic [7:0]    tmr_cnt_ff;
  logic          tmr_ovf_ff;
  logic          cmp_flag_ff;
  logic [7:0]    hold_ff;
  logic [7:0]    result_ff;
  logic          done_ff;
  logic [7:0]    page_ff;
  logic [7:0]    saved_page_ff;
  logic [7:0]    rom_q;
  logic          tmr_tick;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  wire sel_ctrl   = (paddr_i == RCA_REG_CTRL);
  wire sel_status = (paddr_i == RCA_REG_STATUS);
  wire sel_count  = (paddr_i == RCA_REG_COUNT);
  wire sel_result = (paddr_i == RCA_REG_RESULT);
  wire sel_page   = (paddr_i == RCA_REG_PAGE);
  wire apb_acc   = psel_i & penable_i & pready_o;
  wire apb_wr    = apb_acc & pwrite_i;
  wire wr_ctrl   = apb_wr & sel_ctrl;
  wire wr_status = apb_wr & sel_status;
  wire wr_page   = apb_wr & sel_page;
  wire start_req = wr_ctrl & pwdata_i[RCA_CTRL_START];
  wire stop_req  = wr_ctrl & pwdata_i[RCA_CTRL_STOP];
  // write-one-to-clear requests; a same-cycle hardware set wins
  wire ovf_clr   = wr_status & pwdata_i[RCA_ST_OVF];
  wire done_clr  = start_req | (wr_status & pwdata_i[RCA_ST_DONE]);
  wire addr_ok   = sel_ctrl | sel_status | sel_count | sel_result
                 | sel_page;
  wire busy      = (state_ff != RCA_IDLE);
  wire [31:0] status_word = {28'h0, tmr_ovf_ff, cmp_flag_ff, done_ff, busy};
  wire [31:0] rd_mux =
      sel_status ? status_word :
      sel_count  ? {24'h0, hold_ff} :
      sel_result ? {24'h0, result_ff} :
      sel_page   ? {24'h0, page_ff} : 32'h0;

  // ------------------------------------------------------------------
  // lookup address: page and window byte
  // ------------------------------------------------------------------
  localparam logic [7:0] PAGE_BASE = 8'(RCA_TBL_BASE / RCA_PAGE_BYTES);
  wire [7:0] lk_page = PAGE_BASE + {6'h00, hold_ff[7:6]};
  wire [7:0] lk_win  = (hold_ff & RCA_LOW_MASK) + RCA_WIN_BASE;
  wire [7:0] rom_page = (state_ff == RCA_LOOKUP) ? lk_page : page_ff;

  // ------------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RCA_IDLE:   if (start_req) nxt_state = RCA_DISCH;
      RCA_DISCH:  if (bus_en_ff && disch_ff == 8'h01)
                    nxt_state = RCA_RAMP;
      RCA_RAMP:   if (cmp_flag_ff) nxt_state = RCA_CAPT;
      RCA_CAPT:   nxt_state = RCA_LOOKUP;
      RCA_LOOKUP: nxt_state = RCA_STORE;
      RCA_STORE:  nxt_state = RCA_IDLE;
      default:    nxt_state = RCA_IDLE;
    endcase
    if (stop_req) nxt_state = RCA_IDLE;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) state_ff <= RCA_IDLE;
    else        state_ff <= nxt_state;
  end

  // discharge loop counter, one step per bus-rate enable
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      disch_ff <= 8'h00;
    end else if (state_ff != RCA_DISCH) begin
      disch_ff <= 8'(RCA_DISCH_LOOPS);
    end else if (bus_en_ff) begin
      disch_ff <= disch_ff - 8'h01;
    end
  end

  // ------------------------------------------------------------------
  // conversion timer
  // ------------------------------------------------------------------
  rca_prescaler #(
    .DIV (BUS_DIV * PRESCALE)
  ) u_presc (
    .clk_sys_i (clk_sys_i),
    .srst_i    (srst_i),
    .clear_i   (~tmr_run_ff),
    .tick_o    (tmr_tick)
  );

  wire ramp_go = (state_ff == RCA_DISCH) && (nxt_state == RCA_RAMP);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tmr_run_ff <= 1'b0;
      tmr_cnt_ff <= 8'h00;
      tmr_ovf_ff <= 1'b0;
    end else begin
      // clear first so that an overflow in the same cycle still sets
      if (ovf_clr) tmr_ovf_ff <= 1'b0;
      if (ramp_go) begin
        tmr_run_ff <= 1'b1;
        tmr_cnt_ff <= 8'h00;
        tmr_ovf_ff <= 1'b0;
      end else if (state_ff != RCA_RAMP) begin
        tmr_run_ff <= 1'b0;
        tmr_cnt_ff <= 8'h00;
      end else if (tmr_tick) begin
        tmr_cnt_ff <= tmr_cnt_ff + 8'h01;
        if (tmr_cnt_ff == 8'hff) tmr_ovf_ff <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // comparator event flag and capture
  // ------------------------------------------------------------------
  wire cmp_evt = (state_ff == RCA_RAMP) & ramp_comparator_en_o & cmp_rise;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cmp_flag_ff <= 1'b0;
      hold_ff     <= 8'h00;
    end else begin
      if (cmp_evt) begin
        cmp_flag_ff <= 1'b1;
        hold_ff     <= tmr_cnt_ff;
      end else if (state_ff == RCA_CAPT) begin
        cmp_flag_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // table lookup, result and page restore
  // ------------------------------------------------------------------
  rca_table_rom u_rom (
    .clk_sys_i  (clk_sys_i),
    .page_i     (rom_page),
    .win_addr_i (lk_win),
    .data_o     (rom_q)
  );

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      result_ff     <= 8'h00;
      done_ff       <= 1'b0;
      page_ff       <= RCA_PAGE_RST;
      saved_page_ff <= RCA_PAGE_RST;
    end else begin
      if (state_ff == RCA_CAPT) saved_page_ff <= page_ff;
      if (state_ff == RCA_LOOKUP) page_ff <= lk_page;
      if (state_ff == RCA_STORE) begin
        result_ff <= rom_q;
        page_ff   <= saved_page_ff;
        done_ff   <= 1'b1;
      end else if (wr_page && !busy) begin
        page_ff <= pwdata_i[7:0];
      end
      if (done_clr && state_ff != RCA_STORE) done_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // pins and comparator control
  // ------------------------------------------------------------------
  wire [7:0] pin_unused = {7'h00, pin_s2_ff};
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ramp_node_pin_o        <= 1'b0;
      ramp_node_pin_oe_o     <= 1'b0;
      ramp_comparator_en_o   <= 1'b0;
      ramp_comparator_edge_o <= 1'b0;
    end else begin
      ramp_node_pin_o    <= 1'b0;
      ramp_node_pin_oe_o <= (nxt_state == RCA_DISCH);
      ramp_comparator_en_o   <= (nxt_state == RCA_DISCH) ||
                                (nxt_state == RCA_RAMP);
      ramp_comparator_edge_o <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~addr_ok;
      prdata_o  <= (psel_i & ~pwrite_i) ? (rd_mux | {24'h0, 8'h00 & pin_unused})
                                        : 32'h0;
    end
  end
endmodule
`default_nettype wire

// ===== bench/rca_seq_monitor.sv
// rca_seq_monitor: port-level checks of the ramp-compare sequencer
// assumes: bound onto rca_sequencer, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none
module rca_seq_monitor #(
  parameter int BUS_DIV = 25
) (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        ramp_node_pin_i,
  input wire logic        ramp_node_pin_o,
  input wire logic        ramp_node_pin_oe_o,
  input wire logic        ramp_comparator_i,
  input wire logic        ramp_comparator_en_o,
  input wire logic        ramp_comparator_edge_o
);
  localparam int DISCH_MIN = 254 * BUS_DIV - 2;
  localparam int DISCH_MAX = 255 * BUS_DIV + 2;
  logic [15:0] oe_run_ff;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // length of the current discharge interval
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !ramp_node_pin_oe_o) oe_run_ff <= 16'h0000;
    else oe_run_ff <= oe_run_ff + 16'h0001;
  end
  property p_pin_low;
    ramp_node_pin_oe_o |-> !ramp_node_pin_o;
  endproperty
  property p_disch_len;
    $fell(ramp_node_pin_oe_o) |->
      ($past(oe_run_ff) >= DISCH_MIN) && ($past(oe_run_ff) <= DISCH_MAX);
  endproperty
  property p_en_disch;
    ramp_node_pin_oe_o |-> ramp_comparator_en_o;
  endproperty
  property p_ramp_start;
    $fell(ramp_node_pin_oe_o) |-> ramp_comparator_en_o;
  endproperty
  property p_edge_mode;
    !$past(srst_i) && !$past(srst_i, 2) && !$past(srst_i, 3)
      |-> ramp_comparator_edge_o;
  endproperty
  property p_cmp_off;
    ramp_comparator_en_o && !ramp_node_pin_oe_o && $rose(ramp_comparator_i)
      |-> ##[1:8] !ramp_comparator_en_o;
  endproperty
  property p_ready_lat;
    psel_i && penable_i && !$past(penable_i) |=> pready_o;
  endproperty
  property p_ready_pulse;
    pready_o |=> !pready_o;
  endproperty
  property p_err_with_ready;
    pslverr_o |-> pready_o;
  endproperty
  a_pin_low:        assert property (p_pin_low) else $error("pin not low");
  a_disch_len:      assert property (p_disch_len) else $error("discharge length");
  a_en_disch:       assert property (p_en_disch) else $error("comparator off");
  a_ramp_start:     assert property (p_ramp_start) else $error("ramp start");
  a_edge_mode:      assert property (p_edge_mode) else $error("edge mode off");
  a_cmp_off:        assert property (p_cmp_off) else $error("no disable");
  a_ready_lat:      assert property (p_ready_lat) else $error("pready late");
  a_ready_pulse:    assert property (p_ready_pulse) else $error("pready long");
  a_err_with_ready: assert property (p_err_with_ready) else $error("lone pslverr");
  c_ramp:  cover property ($fell(ramp_node_pin_oe_o));
  c_event: cover property (ramp_comparator_en_o && $rose(ramp_comparator_i));
  c_err:   cover property (pslverr_o);
endmodule
bind rca_sequencer rca_seq_monitor #(.BUS_DIV(BUS_DIV)) mon_u (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .ramp_node_pin_i(ramp_node_pin_i),
  .ramp_node_pin_o(ramp_node_pin_o),
  .ramp_node_pin_oe_o(ramp_node_pin_oe_o),
  .ramp_comparator_i(ramp_comparator_i),
  .ramp_comparator_en_o(ramp_comparator_en_o),
  .ramp_comparator_edge_o(ramp_comparator_edge_o));
`default_nettype wire

// ===== bench/rca_rc_model.sv
// rca_rc_model: rc ramp node with a comparator against a fixed input
// assumes: trip time given in clocks after the node is released
`timescale 1ns/1ps
`default_nettype none
module rca_rc_model (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        oe_i,
  input  wire logic        drive_i,
  input  wire logic        en_i,
  input  wire logic [15:0] trip_i,
  output logic             pin_o,
  output logic             cmp_o
);
  logic [15:0] t_ff;
  // node pulled up through the resistor when not driven
  assign pin_o = oe_i ? drive_i : 1'b1;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || oe_i || !en_i) t_ff <= 16'h0000;
    else if (t_ff != 16'hffff) t_ff <= t_ff + 16'h0001;
  end
  // a disabled comparator output is meaningless: toggle it
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) cmp_o <= 1'b0;
    else if (!en_i) cmp_o <= ~cmp_o;
    else cmp_o <= !oe_i && (t_ff >= trip_i);
  end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// tb: register-level test of the ramp-compare conversion sequencer
// assumes: short counts, BUS_DIV 1 and PRESCALE 2
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rca_pkg::*;
  logic clk_sys_i = 1'b0, srst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr, prdy, pin_i, pin_o, pin_oe;
  logic cmp, cen, cedge, e;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, r, cnt, res, prev;
  logic [15:0] trip = 16'hffff;
  int n_errors = 0, samples_checked = 0, k, c;
  int cs[5] = '{5, 63, 64, 65, 250};
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  rca_sequencer #(.BUS_DIV(1), .PRESCALE(2)) dut_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .ramp_node_pin_i(pin_i),
    .ramp_node_pin_o(pin_o), .ramp_node_pin_oe_o(pin_oe),
    .ramp_comparator_i(cmp), .ramp_comparator_en_o(cen),
    .ramp_comparator_edge_o(cedge));
  rca_rc_model model_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .oe_i(pin_oe), .drive_i(pin_o),
    .en_i(cen), .trip_i(trip), .pin_o(pin_i), .cmp_o(cmp));
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one apb transfer; answer taken in the cycle pready is high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    if (prdy !== 1'b1) begin
      n_errors++;
      summarize();
    end
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  function automatic logic [31:0] tbl(input logic [31:0] i);
    tbl = 32'd255 - ((32'd255 - i) * (32'd255 - i)) / 32'd255;
  endfunction
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    apb(0, RCA_REG_PAGE, 0); chk(r, 32'h0);
    apb(0, RCA_REG_STATUS, 0); chk(r, 32'h0);
    apb(0, RCA_REG_CTRL, 0); chk(r, 32'h0);
    apb(0, 8'h20, 0); chk({31'h0, e}, 32'h1); chk(r, 32'h0);
    apb(1, RCA_REG_PAGE, 32'h5a);
    apb(0, RCA_REG_PAGE, 0); chk(r, 32'h5a);
    prev = 32'h0;
    foreach (cs[i]) begin
      c = cs[i];
      trip <= 16'(2 * c + 1);
      apb(1, RCA_REG_CTRL, 32'h1);
      apb(1, RCA_REG_PAGE, 32'ha5);
      k = 0;
      do begin
        apb(0, RCA_REG_STATUS, 0);
        k++;
      end while (r[RCA_ST_DONE] !== 1'b1 && k < 400);
      chk({31'h0, r[RCA_ST_DONE]}, 32'h1);
      if (r[RCA_ST_DONE] !== 1'b1) summarize();
      chk({31'h0, r[RCA_ST_BUSY]}, 32'h0);
      apb(0, RCA_REG_COUNT, 0); cnt = r;
      chk({31'h0, (cnt + 1 >= c) && (cnt <= c + 2)}, 32'h1);
      apb(0, RCA_REG_RESULT, 0); res = r;
      chk(res, tbl(cnt));
      chk({31'h0, res >= prev}, 32'h1);
      prev = res;
      apb(0, RCA_REG_PAGE, 0); chk(r, 32'h5a);
      apb(1, RCA_REG_STATUS, 32'h2);
      apb(0, RCA_REG_STATUS, 0); chk(r & 32'h3, 32'h0);
    end
    trip <= 16'hffff;
    apb(1, RCA_REG_CTRL, 32'h1);
    repeat (900) @(posedge clk_sys_i);
    apb(0, RCA_REG_STATUS, 0); chk({31'h0, r[RCA_ST_OVF]}, 32'h1);
    apb(1, RCA_REG_CTRL, 32'h2);
    apb(0, RCA_REG_STATUS, 0); chk({31'h0, r[RCA_ST_BUSY]}, 32'h0);
    apb(1, RCA_REG_STATUS, 32'h8);
    apb(0, RCA_REG_STATUS, 0); chk({31'h0, r[RCA_ST_OVF]}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
